// ---- verilog/psq_top.sv ----
// program sequencer: counter, return stack, alu and table reads
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "psq_defs.svh"

// How it works
// - counter steps by one per executed instruction unless control moves elsewhere
// - only the low counter byte is a software register, read and write
// - jump, call, interrupt and reset load the counter with a target
// - a taken skip discards the prefetched word with one dummy cycle
// - high part is two bits on the small variant, three on the large
// - writing the low byte jumps within the current 256-word page
// - a low-byte write jump inserts one dummy cycle
// - stack and its pointer are hidden from software
// - call and interrupt acknowledge push the counter
// - both returns pop the stack into the counter
// - reset leaves the stack empty
// - interrupt waits while stack is full, taken after a return frees a level
// - a call on a full stack proceeds and loses the oldest entry
// - alu writes its result and updates carry and the other flags
// - alu covers arithmetic, logic, rotates, inc, dec and skip decisions
// - program memory is 1K by 14 or 2K by 15, addressed by the counter
// - after reset execution starts at the reset vector
// - table read gives low byte to a data register, high part to table high
// - table high bits without a word bit read as zero
// - current-page table read takes the page from the counter
// - last-page table read takes the last page of memory
// - a table read takes two instruction cycles
module psq_top (
   input  wire logic                    mclk,
   input  wire logic                    rstn,
   input  wire psq_pkg::psq_cmd_t       cmd,
   input  wire logic                    irq_req,
   input  wire logic [`PSQ_WW-1:0]      pm_rdata,
   input  wire logic [`PSQ_REG_AW-1:0]  reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [`PSQ_PCW-1:0]          pm_addr_q,
   output logic [7:0]                   reg_rdata_q,
   output psq_pkg::psq_seq_t            seq_q,
   output psq_pkg::psq_alu_res_t        alu_q,
   output psq_pkg::psq_tbl_t            tbl_q
);

   localparam int PCW = `PSQ_PCW;
   localparam int WW  = `PSQ_WW;
   localparam int DEP = `PSQ_STK_DEPTH;
   localparam int LW  = `PSQ_LOW_W;

   logic [PCW-1:0]            pc_q;
   logic [PCW-1:0]            pc_d;
   logic [PCW-1:0]            tgt;
   logic [PCW-1:0]            tbl_addr;
   logic [PCW-1:0]            stk_q [DEP];
   logic [`PSQ_STK_IW-1:0]    top_q;
   logic [`PSQ_STK_CW-1:0]    cnt_q;
   logic [7:0]                table_high_byte_q;
   logic                      irq_pend_q;
   logic                      live;
   logic                      full;
   logic                      redir;
   logic                      push;
   logic                      pop;
   logic                      tbl_go;
   logic                      take;
   logic                      skip_hit;
   logic                      pcl_wr;
   logic [7:0]                bb;
   logic                      ci;
   logic [8:0]                sum;
   logic [4:0]                nib;
   logic [7:0]                res;
   logic                      cy;
   logic                      hc;
   logic                      ov;
   logic                      zr;

   // a dummy or hold slot carries no instruction, so the command is ignored
   assign live   = !seq_q.dummy && !seq_q.hold;
   assign full   = cnt_q == `PSQ_STK_CW'(DEP);
   assign pcl_wr = reg_wr && reg_addr == `PSQ_REG_PC_LOW;

   // alu
   always_comb begin
      bb  = (cmd.alu == psq_pkg::PSQ_ALU_SUB || cmd.alu == psq_pkg::PSQ_ALU_SBC)
            ? ~cmd.b : cmd.b;
      ci  = (cmd.alu == psq_pkg::PSQ_ALU_ADD) ? 1'b0 :
            (cmd.alu == psq_pkg::PSQ_ALU_SUB) ? 1'b1 : cmd.cin;
      sum = {1'b0, cmd.a} + {1'b0, bb} + {8'h00, ci};
      nib = {1'b0, cmd.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      res = cmd.a;
      cy  = cmd.cin;
      hc  = cmd.acin;
      ov  = 1'b0;
      case (cmd.alu)
         psq_pkg::PSQ_ALU_ADD, psq_pkg::PSQ_ALU_ADC,
         psq_pkg::PSQ_ALU_SUB, psq_pkg::PSQ_ALU_SBC: begin
            // subtract keeps carry high when no borrow occurs
            res = sum[7:0];
            cy  = sum[8];
            hc  = nib[4];
            ov  = (cmd.a[7] == bb[7]) && (sum[7] != cmd.a[7]);
         end
         psq_pkg::PSQ_ALU_DAA: begin
            sum = {1'b0, cmd.a};
            if (cmd.a[3:0] > 4'h9 || cmd.acin) begin
               sum = sum + 9'h006;
            end
            if (sum[7:4] > 4'h9 || sum[8] || cmd.cin) begin
               sum = sum + 9'h060;
            end
            res = sum[7:0];
            cy  = sum[8] || cmd.cin;
         end
         psq_pkg::PSQ_ALU_AND:  res = cmd.a & cmd.b;
         psq_pkg::PSQ_ALU_OR:   res = cmd.a | cmd.b;
         psq_pkg::PSQ_ALU_XOR:  res = cmd.a ^ cmd.b;
         psq_pkg::PSQ_ALU_CPL:  res = ~cmd.a;
         psq_pkg::PSQ_ALU_RR:   res = {cmd.a[0], cmd.a[7:1]};
         psq_pkg::PSQ_ALU_RL:   res = {cmd.a[6:0], cmd.a[7]};
         psq_pkg::PSQ_ALU_RRC: begin
            res = {cmd.cin, cmd.a[7:1]};
            cy  = cmd.a[0];
         end
         psq_pkg::PSQ_ALU_RLC: begin
            res = {cmd.a[6:0], cmd.cin};
            cy  = cmd.a[7];
         end
         psq_pkg::PSQ_ALU_INC:  res = cmd.a + 8'h01;
         psq_pkg::PSQ_ALU_DEC:  res = cmd.a - 8'h01;
         default:               res = cmd.a;
      endcase
   end

   assign zr       = res == 8'h00;
   assign skip_hit = (cmd.skip == psq_pkg::PSQ_SKIP_ZERO && zr) ||
                     (cmd.skip == psq_pkg::PSQ_SKIP_NZERO && !zr);

   // page part from the counter, or all ones for the last page
   always_comb begin
      if (cmd.op == psq_pkg::PSQ_OP_TABLE_LAST) begin
         tbl_addr = {{(PCW-LW){1'b1}}, cmd.tbl_ptr};
      end else begin
         tbl_addr = {pc_q[PCW-1:LW], cmd.tbl_ptr};
      end
   end

   // next fetch decision
   always_comb begin
      redir  = 1'b0;
      push   = 1'b0;
      pop    = 1'b0;
      tbl_go = 1'b0;
      take   = 1'b0;
      tgt    = pc_q;
      if (live) begin
         case (cmd.op)
            psq_pkg::PSQ_OP_JUMP: begin
               redir = 1'b1;
               tgt   = cmd.target[PCW-1:0];
            end
            psq_pkg::PSQ_OP_CALL: begin
               redir = 1'b1;
               push  = 1'b1;
               tgt   = cmd.target[PCW-1:0];
            end
            psq_pkg::PSQ_OP_RETURN_SUB, psq_pkg::PSQ_OP_RETURN_INT: begin
               redir = 1'b1;
               pop   = 1'b1;
               tgt   = stk_q[top_q - 2'h1];
            end
            psq_pkg::PSQ_OP_TABLE_CUR, psq_pkg::PSQ_OP_TABLE_LAST: begin
               tbl_go = 1'b1;
            end
            psq_pkg::PSQ_OP_ALU: begin
               // the word already fetched is skipped over
               if (skip_hit) begin
                  redir = 1'b1;
                  tgt   = PCW'(pc_q + 1'b1);
               end
            end
            default: redir = 1'b0;
         endcase
      end
      // a low-byte write keeps the page; an instruction jump has priority
      if (pcl_wr && !redir && !tbl_go) begin
         redir = 1'b1;
         tgt   = {pc_q[PCW-1:LW], reg_wdata};
      end
      // a full stack holds the request back until a return frees a level
      if (irq_pend_q && !full && live && !redir && !tbl_go) begin
         take  = 1'b1;
         redir = 1'b1;
         push  = 1'b1;
         tgt   = `PSQ_IRQ_VEC;
      end
   end

   always_comb begin
      if (redir) begin
         pc_d = tgt;
      end else if (seq_q.hold) begin
         pc_d = pc_q;
      end else begin
         pc_d = PCW'(pc_q + 1'b1);
      end
   end

   // counter and fetch address
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pc_q      <= `PSQ_RESET_VEC;
         pm_addr_q <= `PSQ_RESET_VEC;
      end else begin
         pc_q      <= pc_d;
         pm_addr_q <= tbl_go ? tbl_addr : pc_d;
      end
   end

   // return stack: a ring, so overflow overwrites the oldest level
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         top_q <= 2'h0;
         cnt_q <= 3'h0;
      end else if (push) begin
         top_q <= top_q + 2'h1;
         cnt_q <= full ? cnt_q : cnt_q + 3'h1;
      end else if (pop) begin
         top_q <= top_q - 2'h1;
         cnt_q <= (cnt_q == 3'h0) ? 3'h0 : cnt_q - 3'h1;
      end
   end

   // entries hold addresses only and never reach the register port
   always_ff @(posedge mclk) begin
      if (push) begin
         stk_q[top_q] <= pc_q;
      end
   end

   // sequencing status; reset counts as a dummy slot
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         seq_q      <= '{dummy: 1'b1, hold: 1'b0, irq_ack: 1'b0};
         irq_pend_q <= 1'b0;
      end else begin
         seq_q.dummy   <= redir;
         seq_q.hold    <= tbl_go;
         seq_q.irq_ack <= take;
         irq_pend_q    <= irq_req || (irq_pend_q && !take);
      end
   end

   // alu result
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         alu_q <= '0;
      end else begin
         alu_q.valid <= live && cmd.op == psq_pkg::PSQ_OP_ALU;
         alu_q.data  <= res;
         alu_q.c     <= cy;
         alu_q.ac    <= hc;
         alu_q.z     <= zr;
         alu_q.ov    <= ov;
      end
   end

   // table data; it cannot be saved and restored, so handlers must not share it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tbl_q  <= '0;
         table_high_byte_q <= `PSQ_TAB_HI_RST;
      end else begin
         tbl_q.valid <= seq_q.hold;
         tbl_q.data  <= pm_rdata[7:0];
         if (seq_q.hold) begin
            table_high_byte_q <= {{(16-WW){1'b0}}, pm_rdata[WW-1:LW]};
         end
      end
   end

   // register read port
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd && reg_addr == `PSQ_REG_PC_LOW) begin
         reg_rdata_q <= pc_q[LW-1:0];
      end else if (reg_rd && reg_addr == `PSQ_REG_TAB_HI) begin
         reg_rdata_q <= table_high_byte_q;
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   logic seq_ok;
   assign seq_ok = live && cmd.op == psq_pkg::PSQ_OP_SEQ && !reg_wr && !irq_pend_q;

   pc_step_a: assert property (seq_ok && !seq_q.hold |=> pc_q == PCW'($past(pc_q) + 1'b1))
      else $error("counter did not step by one");
   pc_wrap_a: assert property (seq_ok && pc_q == {PCW{1'b1}} |=> pc_q == '0)
      else $error("counter did not wrap");
   jump_load_a: assert property (live && cmd.op == psq_pkg::PSQ_OP_JUMP && !irq_pend_q
         |=> pc_q == $past(cmd.target[PCW-1:0]) && seq_q.dummy && !tbl_q.valid)
      else $error("jump target not loaded");
   unmapped_read_a: assert property (reg_rd && reg_addr != `PSQ_REG_PC_LOW
         && reg_addr != `PSQ_REG_TAB_HI |=> reg_rdata_q == 8'h00)
      else $error("unmapped read not zero");
   page_jump_a: assert property (live && cmd.op == psq_pkg::PSQ_OP_SEQ && pcl_wr
         |=> pc_q == {$past(pc_q[PCW-1:LW]), $past(reg_wdata)} && seq_q.dummy)
      else $error("low byte write did not jump within page");
   call_return_a: assert property (live && cmd.op == psq_pkg::PSQ_OP_CALL ##2
         live && cmd.op == psq_pkg::PSQ_OP_RETURN_SUB |=> pc_q == $past(pc_q, 3))
      else $error("return did not restore pushed address");
   reset_state_a: assert property (disable iff (1'b0) !rstn
         |=> pc_q == `PSQ_RESET_VEC && cnt_q == 3'h0 && seq_q.dummy)
      else $error("reset state wrong");
   irq_full_a: assert property (full && !pop |=> !seq_q.irq_ack)
      else $error("interrupt taken on full stack");
   overflow_a: assert property (full && live && cmd.op == psq_pkg::PSQ_OP_CALL
         |=> full && pc_q == $past(cmd.target[PCW-1:0]))
      else $error("call on full stack did not proceed");
   skip_a: assert property (live && cmd.op == psq_pkg::PSQ_OP_ALU && skip_hit && !pcl_wr
         |=> seq_q.dummy && pc_q == PCW'($past(pc_q) + 1'b1))
      else $error("skip did not discard prefetched word");
   add_a: assert property (live && cmd.op == psq_pkg::PSQ_OP_ALU
         && cmd.alu == psq_pkg::PSQ_ALU_ADD
         |=> {alu_q.c, alu_q.data} == {1'b0, $past(cmd.a)} + {1'b0, $past(cmd.b)}
         && alu_q.z == (alu_q.data == 8'h00))
      else $error("add result or flags wrong");
   table_two_a: assert property (tbl_go |=> seq_q.hold ##1 (tbl_q.valid && !seq_q.hold))
      else $error("table read not two cycles");
   table_last_a: assert property (tbl_go && cmd.op == psq_pkg::PSQ_OP_TABLE_LAST
         |=> pm_addr_q == {{(PCW-LW){1'b1}}, $past(cmd.tbl_ptr)})
      else $error("last page address wrong");
   table_high_a: assert property (seq_q.hold |=> table_high_byte_q[7:WW-LW] == '0
         && table_high_byte_q[WW-LW-1:0] == $past(pm_rdata[WW-1:LW]))
      else $error("table high byte wrong");
   low_read_a: assert property (reg_rd && reg_addr == `PSQ_REG_PC_LOW
         |=> reg_rdata_q == $past(pc_q[LW-1:0]))
      else $error("low byte read wrong");

   call_full_c:  cover property (full && live && cmd.op == psq_pkg::PSQ_OP_CALL);
   irq_take_c:   cover property (irq_pend_q ##1 seq_q.irq_ack);
   table_read_c: cover property (tbl_go ##2 tbl_q.valid);
   skip_take_c:  cover property (live && cmd.op == psq_pkg::PSQ_OP_ALU && skip_hit);

endmodule // psq_top
`default_nettype wire

// ---- include/psq_defs.svh ----
// constants of the program sequencer: sizes, vectors and register offsets
`ifndef PSQ_DEFS_SVH
`define PSQ_DEFS_SVH

// larger variant: 11-bit counter, 15-bit words; smaller: 10 and 14
`define PSQ_LARGE       1
`define PSQ_PCW         ((`PSQ_LARGE != 0) ? 11 : 10)
`define PSQ_WW          ((`PSQ_LARGE != 0) ? 15 : 14)
`define PSQ_LOW_W       8
`define PSQ_TGT_W       11

`define PSQ_STK_DEPTH   4
`define PSQ_STK_IW      2
`define PSQ_STK_CW      3

`define PSQ_RESET_VEC   11'h000
`define PSQ_IRQ_VEC     11'h004

`define PSQ_REG_AW      4
`define PSQ_REG_PC_LOW  4'h0
`define PSQ_REG_TAB_HI  4'h1
`define PSQ_TAB_HI_RST  8'h00

`endif

// ---- include/psq_pkg.sv ----
// types of the program sequencer
`include "psq_defs.svh"
package psq_pkg;

   typedef enum logic [2:0] {
      PSQ_OP_SEQ        = 3'h0,
      PSQ_OP_JUMP       = 3'h1,
      PSQ_OP_CALL       = 3'h2,
      PSQ_OP_RETURN_SUB = 3'h3,
      PSQ_OP_RETURN_INT = 3'h4,
      PSQ_OP_TABLE_CUR  = 3'h5,
      PSQ_OP_TABLE_LAST = 3'h6,
      PSQ_OP_ALU        = 3'h7
   } psq_op_t;

   typedef enum logic [3:0] {
      PSQ_ALU_ADD  = 4'h0,
      PSQ_ALU_ADC  = 4'h1,
      PSQ_ALU_SUB  = 4'h2,
      PSQ_ALU_SBC  = 4'h3,
      PSQ_ALU_DAA  = 4'h4,
      PSQ_ALU_AND  = 4'h5,
      PSQ_ALU_OR   = 4'h6,
      PSQ_ALU_XOR  = 4'h7,
      PSQ_ALU_CPL  = 4'h8,
      PSQ_ALU_RR   = 4'h9,
      PSQ_ALU_RRC  = 4'hA,
      PSQ_ALU_RL   = 4'hB,
      PSQ_ALU_RLC  = 4'hC,
      PSQ_ALU_INC  = 4'hD,
      PSQ_ALU_DEC  = 4'hE,
      PSQ_ALU_PASS = 4'hF
   } psq_alu_op_t;

   typedef enum logic [1:0] {
      PSQ_SKIP_NONE  = 2'h0,
      PSQ_SKIP_ZERO  = 2'h1,
      PSQ_SKIP_NZERO = 2'h2
   } psq_skip_t;

   typedef struct packed {
      psq_op_t                op;
      psq_alu_op_t            alu;
      psq_skip_t              skip;
      logic [`PSQ_TGT_W-1:0]  target;
      logic [7:0]             tbl_ptr;
      logic [7:0]             a;
      logic [7:0]             b;
      logic                   cin;
      logic                   acin;
   } psq_cmd_t;

   typedef struct packed {
      logic dummy;
      logic hold;
      logic irq_ack;
   } psq_seq_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       c;
      logic       ac;
      logic       z;
      logic       ov;
   } psq_alu_res_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } psq_tbl_t;

endpackage

// ---- dv/psq_pmem_model.sv ----
// program memory model: combinational read of an address-derived word
`timescale 1ns/1ps
`default_nettype none
`include "psq_defs.svh"
module psq_pmem_model (
   input  wire logic [`PSQ_PCW-1:0] addr,
   output logic      [`PSQ_WW-1:0]  rdata
);
   // only the low eight address bits shape the word, so a wrong page bit of the fetch address does not show
   assign rdata = {addr[6:0], ~addr[7:0]};
endmodule // psq_pmem_model
`default_nettype wire

// ---- dv/tb_psq_top.sv ----
// self-checking bench of the program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "psq_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_psq_top;
   logic                     mclk;
   logic                     rstn;
   logic                     irq_req;
   logic                     reg_wr;
   logic                     reg_rd;
   logic [`PSQ_REG_AW-1:0]   reg_addr;
   logic [7:0]               reg_wdata;
   logic [7:0]               reg_rdata_q;
   logic [7:0]               rdv;
   logic [`PSQ_WW-1:0]       pm_rdata;
   logic [`PSQ_PCW-1:0]      pm_addr_q;
   logic [`PSQ_PCW-1:0]      pc0;
   logic [`PSQ_PCW-1:0]      ret [5];
   psq_pkg::psq_cmd_t        cmd;
   psq_pkg::psq_cmd_t        idle;
   psq_pkg::psq_seq_t        seq_q;
   psq_pkg::psq_alu_res_t    alu_q;
   psq_pkg::psq_tbl_t        tbl_q;
   int                       error_cnt;
   int                       checked;
   // operands 96 and 7B, carry in 1: {carry, result} for each alu code
   logic [8:0] ex [16] = '{9'h111, 9'h112, 9'h11B, 9'h11B, 9'h1F6, 9'h112, 9'h1FF,
      9'h1ED, 9'h169, 9'h14B, 9'h0CB, 9'h12D, 9'h12D, 9'h197, 9'h195, 9'h196};

   psq_top i_dut (
      .mclk        (mclk),
      .rstn        (rstn),
      .cmd         (cmd),
      .irq_req     (irq_req),
      .pm_rdata    (pm_rdata),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .pm_addr_q   (pm_addr_q),
      .reg_rdata_q (reg_rdata_q),
      .seq_q       (seq_q),
      .alu_q       (alu_q),
      .tbl_q       (tbl_q)
   );
   psq_pmem_model i_pmem (.addr(pm_addr_q), .rdata(pm_rdata));

   task automatic test_done;
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // hold the command until a live slot takes it; returns with its result settled
   task automatic issue(input psq_pkg::psq_cmd_t c);
      int n;
      n = 0;
      @(posedge mclk);
      cmd <= c;
      @(negedge mclk);
      while ((seq_q.dummy !== 1'b0 || seq_q.hold !== 1'b0) && n < 20) begin
         n++;
         @(negedge mclk);
      end
      pc0 = pm_addr_q;
      @(posedge mclk);
      cmd <= idle;
      @(negedge mclk);
   endtask

   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= w;
      reg_rd    <= !w;
      @(negedge mclk);
      pc0 = pm_addr_q;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge mclk);
      rdv = reg_rdata_q;
   endtask

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial begin
      repeat (3000) @(posedge mclk);
      error_cnt++;
      test_done();
   end

   initial begin
      psq_pkg::psq_cmd_t c;
      logic [`PSQ_PCW-1:0] ta;
      logic [`PSQ_PCW-1:0] last;
      int k;
      error_cnt = 0;
      checked = 0;
      idle = '0;
      cmd = '0;
      rstn = 1'b0;
      irq_req = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      @(negedge mclk);
      `CHK("pc_reset", 11'h000, pm_addr_q)
      acc(1'b0, `PSQ_REG_TAB_HI, 8'h00);
      `CHK("tbh_reset", 8'h00, rdv)
      for (int i = 0; i < 3; i++) begin
         issue(idle);
         `CHK("pc_step", pc0 + 11'h001, pm_addr_q)
      end
      c = idle;
      c.op = psq_pkg::PSQ_OP_JUMP;
      c.target = 11'h7FE;
      issue(c);
      issue(idle);
      `CHK("pc_wrap", 11'h000, pm_addr_q)
      c.target = 11'h512;
      issue(c);
      `CHK("jump", 11'h512, pm_addr_q)
      `CHK("jump_dummy", 1'b1, seq_q.dummy)
      acc(1'b1, `PSQ_REG_PC_LOW, 8'hA5);
      `CHK("pcl_jump", {pc0[10:8], 8'hA5}, pm_addr_q)
      `CHK("pcl_dummy", 1'b1, seq_q.dummy)
      acc(1'b0, `PSQ_REG_PC_LOW, 8'h00);
      `CHK("pcl_read", pc0[7:0], rdv)
      acc(1'b1, `PSQ_REG_TAB_HI, 8'h33);
      acc(1'b0, `PSQ_REG_TAB_HI, 8'h00);
      `CHK("tbh_ro", 8'h00, rdv)
      acc(1'b0, 4'hF, 8'h00);
      `CHK("unmapped", 8'h00, rdv)
      // table reads run in main code only, never while a handler is live
      for (int i = 0; i < 2; i++) begin
         c = idle;
         c.op = i ? psq_pkg::PSQ_OP_TABLE_LAST : psq_pkg::PSQ_OP_TABLE_CUR;
         c.tbl_ptr = 8'h06 + 8'(i * 21);
         issue(c);
         ta = i ? {{(`PSQ_PCW - 8){1'b1}}, c.tbl_ptr} : {pc0[10:8], c.tbl_ptr};
         `CHK("tbl_addr", ta, pm_addr_q)
         `CHK("tbl_hold", 1'b1, seq_q.hold)
         @(negedge mclk);
         `CHK("tbl_valid", 1'b1, tbl_q.valid)
         `CHK("tbl_low", ~ta[7:0], tbl_q.data)
         acc(1'b0, `PSQ_REG_TAB_HI, 8'h00);
         `CHK("tbl_high", {1'b0, ta[6:0]}, rdv)
      end
      for (int i = 0; i < 16; i++) begin
         c = idle;
         c.op = psq_pkg::PSQ_OP_ALU;
         c.alu = psq_pkg::psq_alu_op_t'(4'(i));
         c.a = 8'h96;
         c.b = 8'h7B;
         c.cin = 1'b1;
         issue(c);
         `CHK("alu_valid", 1'b1, alu_q.valid)
         `CHK("alu_data", ex[i][7:0], alu_q.data)
         if (i != 4) `CHK("alu_carry", ex[i][8], alu_q.c)
         if (i == 0) `CHK("alu_half", 1'b1, alu_q.ac)
         if (i == 2) `CHK("alu_ovf", 1'b1, alu_q.ov)
      end
      for (int i = 0; i < 2; i++) begin
         c = idle;
         c.op = psq_pkg::PSQ_OP_ALU;
         c.alu = psq_pkg::PSQ_ALU_DEC;
         c.a = 8'h01;
         c.skip = i ? psq_pkg::PSQ_SKIP_NZERO : psq_pkg::PSQ_SKIP_ZERO;
         issue(c);
         `CHK("skip_dummy", 1'(i == 0), seq_q.dummy)
         `CHK("skip_pc", pc0 + 11'h001, pm_addr_q)
         `CHK("alu_zero", 1'b1, alu_q.z)
      end
      // stack starts empty, so four calls fill it and the interrupt must wait
      for (int i = 0; i < 4; i++) begin
         c = idle;
         c.op = psq_pkg::PSQ_OP_CALL;
         c.target = 11'h100 + 11'(i * 16);
         issue(c);
         ret[i] = pc0;
         `CHK("call", c.target, pm_addr_q)
      end
      @(posedge mclk);
      irq_req <= 1'b1;
      @(posedge mclk);
      irq_req <= 1'b0;
      repeat (6) begin
         @(negedge mclk);
         `CHK("ack_full", 1'b0, seq_q.irq_ack)
      end
      c = idle;
      c.op = psq_pkg::PSQ_OP_RETURN_SUB;
      issue(c);
      `CHK("ret", ret[3], pm_addr_q)
      k = 0;
      last = pm_addr_q;
      while (seq_q.irq_ack !== 1'b1 && k < 10) begin
         last = pm_addr_q;
         k++;
         @(negedge mclk);
      end
      `CHK("ack", 1'b1, seq_q.irq_ack)
      `CHK("irq_vec", `PSQ_IRQ_VEC, pm_addr_q)
      c.op = psq_pkg::PSQ_OP_RETURN_INT;
      issue(c);
      `CHK("return_from_interrupt", last, pm_addr_q)
      c.op = psq_pkg::PSQ_OP_RETURN_SUB;
      for (int i = 2; i >= 0; i--) begin
         issue(c);
         `CHK("ret", ret[i], pm_addr_q)
      end
      // fifth call overflows: the oldest saved address is lost
      for (int i = 0; i < 5; i++) begin
         c = idle;
         c.op = psq_pkg::PSQ_OP_CALL;
         c.target = 11'h200 + 11'(i * 16);
         issue(c);
         ret[i] = pc0;
      end
      c.op = psq_pkg::PSQ_OP_RETURN_SUB;
      for (int i = 4; i > 0; i--) begin
         issue(c);
         `CHK("ovf_ret", ret[i], pm_addr_q)
      end
      test_done();
   end
endmodule // tb_psq_top
`default_nettype wire
